// ---- hw/prog_link_access.sv ----
// access layer of the serial programming link: instruction decode,
// control/status space, unlock key and turnaround guard time
// assumes the physical layer runs on clk_sys_i and hands over whole
// bytes, fault pulses and bit-time ticks; it sends tx_byte_o once
// tx_valid_o and tx_ready_i are both high
//
// Function
// - i/o-write stores next byte at the six scattered address bits
// - control-space read loads addressed byte for serial read-out
// - control-space write stores next byte at low four address bits
// - key instruction is followed by exactly eight key bytes
// - programming disabled after reset, enabled only by exact key
// - writing zero to programming-enabled bit disables programming
// - control/status registers reachable only by control-space access
// - status at 0x0, link control at 0x2, ident at 0xF
// - ident register returns fixed eight-bit identification code
// - unused status and link control bits read zero
// - guard-time field adds idle bits only on receive-to-transmit
// - turnaround idle equals guard time plus two bits
// - guard codes 0..7 give 128,64,32,16,8,4,2,0 extra bits
// - status resets to zero, enable bit reads live enable state
// - instruction then operands; device sends only read operands
// - link fault aborts and holds error state until a break
`include "prog_link_regs.svh"

module prog_link_access
#(
   parameter logic [7:0] IDENT_CODE = `IDENT_CODE_DEFAULT
)
(
   input  wire logic                       clk_sys_i,
   input  wire logic                       reset_i,
   input  wire prog_link_pkg::rx_byte_t    rx_i,
   input  wire prog_link_pkg::link_fault_t fault_i,
   input  wire logic                       bit_tick_i,
   input  wire logic                       tx_ready_i,
   output logic                            tx_valid_o,
   output logic [7:0]                      tx_byte_o,
   output prog_link_pkg::io_write_t        io_write_o,
   output logic                            prog_enabled_o,
   output logic [2:0]                      guard_time_sel_o,
   output logic                            error_o,
   output logic                            other_instr_o,
   output logic [7:0]                      other_opcode_o
);

   prog_link_pkg::acc_regs_t q;
   prog_link_pkg::acc_regs_t d;

   logic        any_fault;
   logic        turn_start;
   logic        turn_done;
   logic [63:0] key_next;
   logic        key_last;
   logic        key_hit;

   assign any_fault = fault_i.parity | fault_i.frame
                    | fault_i.collision | fault_i.brk;
   assign key_next  = {rx_i.data, q.key[63:8]};
   assign key_last  = q.key_cnt == `KEY_LAST_INDEX;
   assign key_hit   = q.state == prog_link_pkg::ST_KEY_DATA && rx_i.valid
                    && !any_fault && key_last && key_next == `UNLOCK_KEY;

   always_comb
   begin
      d             = q;
      d.io_wr       = 1'b0;
      d.other_instr = 1'b0;
      turn_start    = 1'b0;
      if (any_fault)
      begin
         if (q.state == prog_link_pkg::ST_ERROR)
         begin
            if (fault_i.brk)
               d.state = prog_link_pkg::ST_IDLE;
         end
         else
         begin
            d.state    = prog_link_pkg::ST_ERROR;
            d.tx_valid = 1'b0;
         end
      end
      else
      begin
         case (q.state)
            prog_link_pkg::ST_IDLE:
            begin
               if (rx_i.valid)
               begin
                  if ((rx_i.data & `OPC_IO_WRITE_MASK) == `OPC_IO_WRITE_VAL)
                  begin
                     d.addr  = {rx_i.data[6:5], rx_i.data[3:0]};
                     d.state = prog_link_pkg::ST_IO_DATA;
                  end
                  else if ((rx_i.data & `OPC_CS_READ_MASK)
                           == `OPC_CS_READ_VAL)
                  begin
                     d.addr    = {2'b00, rx_i.data[3:0]};
                     d.tx_byte = prog_link_pkg::css_read(rx_i.data[3:0],
                                    q.prog_en, q.guard_sel,
                                    IDENT_CODE);
                     turn_start = 1'b1;
                     d.state    = prog_link_pkg::ST_CS_RD_WAIT;
                  end
                  else if ((rx_i.data & `OPC_CS_WRITE_MASK)
                           == `OPC_CS_WRITE_VAL)
                  begin
                     d.addr  = {2'b00, rx_i.data[3:0]};
                     d.state = prog_link_pkg::ST_CS_WR_DATA;
                  end
                  else if ((rx_i.data & `OPC_KEY_MASK) == `OPC_KEY_VAL)
                  begin
                     d.key_cnt = 4'h0;
                     d.state   = prog_link_pkg::ST_KEY_DATA;
                  end
                  else
                  begin
                     d.other_instr = 1'b1;
                     d.byte_hold   = rx_i.data;
                  end
               end
            end
            prog_link_pkg::ST_IO_DATA:
            begin
               if (rx_i.valid)
               begin
                  d.io_wr     = 1'b1;
                  d.byte_hold = rx_i.data;
                  d.state     = prog_link_pkg::ST_IDLE;
               end
            end
            prog_link_pkg::ST_CS_WR_DATA:
            begin
               if (rx_i.valid)
               begin
                  case (q.addr[3:0])
                     `CSS_ADDR_STATUS:
                     begin
                        if (!rx_i.data[`STATUS_PROG_EN_BIT])
                           d.prog_en = 1'b0;
                     end
                     `CSS_ADDR_LINK_CTRL:
                        d.guard_sel = rx_i.data[`LINK_CTRL_GT_MSB:0];
                     default:
                        d.guard_sel = q.guard_sel;
                  endcase
                  d.state = prog_link_pkg::ST_IDLE;
               end
            end
            prog_link_pkg::ST_CS_RD_WAIT:
            begin
               if (turn_done)
               begin
                  d.tx_valid = 1'b1;
                  d.state    = prog_link_pkg::ST_CS_RD_SEND;
               end
            end
            prog_link_pkg::ST_CS_RD_SEND:
            begin
               if (tx_ready_i)
               begin
                  d.tx_valid = 1'b0;
                  d.state    = prog_link_pkg::ST_IDLE;
               end
            end
            prog_link_pkg::ST_KEY_DATA:
            begin
               if (rx_i.valid)
               begin
                  d.key     = key_next;
                  d.key_cnt = q.key_cnt + 4'h1;
                  if (key_last)
                  begin
                     d.prog_en = key_next == `UNLOCK_KEY;
                     d.state   = prog_link_pkg::ST_IDLE;
                  end
               end
            end
            prog_link_pkg::ST_ERROR:
               d.state = prog_link_pkg::ST_ERROR;
            default:
               d.state = prog_link_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         q           <= '0;
         q.state     <= prog_link_pkg::ST_IDLE;
         q.prog_en   <= 1'(`STATUS_RESET >> `STATUS_PROG_EN_BIT);
         q.guard_sel <= `GUARD_SEL_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   turnaround_timer u_turn
   (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .start_i     (turn_start),
      .abort_i     (any_fault),
      .bit_tick_i  (bit_tick_i),
      .guard_sel_i (q.guard_sel),
      .done_o      (turn_done)
   );

   assign tx_valid_o       = q.tx_valid;
   assign tx_byte_o        = q.tx_byte;
   assign io_write_o.valid = q.io_wr;
   assign io_write_o.addr  = q.addr;
   assign io_write_o.data  = q.byte_hold;
   assign prog_enabled_o   = q.prog_en;
   assign guard_time_sel_o = q.guard_sel;
   assign error_o          = q.state == prog_link_pkg::ST_ERROR;
   assign other_instr_o    = q.other_instr;
   assign other_opcode_o   = q.byte_hold;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);

   a_io_write_data: assert property (
      q.state == prog_link_pkg::ST_IO_DATA && rx_i.valid && !any_fault
      |=> io_write_o.valid && io_write_o.data == $past(rx_i.data)
          && io_write_o.addr == $past(q.addr))
      else $error("i/o write not issued with shifted-in byte");

   a_cs_read_value: assert property (
      tx_valid_o |-> tx_byte_o == prog_link_pkg::css_read(q.addr[3:0],
                         q.prog_en, q.guard_sel, IDENT_CODE))
      else $error("read-out byte differs from control space");

   a_status_zero_bits: assert property (
      q.state == prog_link_pkg::ST_IDLE && rx_i.valid && !any_fault
      && rx_i.data == 8'h80
      |=> q.tx_byte == {6'h00, $past(q.prog_en), 1'b0})
      else $error("status register read shows reserved bits");

   a_key_unlock: assert property (
      q.state == prog_link_pkg::ST_KEY_DATA && rx_i.valid && !any_fault
      && key_last && key_next == `UNLOCK_KEY |=> prog_enabled_o)
      else $error("correct key did not enable programming");

   a_enable_cause: assert property (
      $rose(prog_enabled_o) |-> $past(key_hit))
      else $error("programming enabled without the unlock key");

   a_enable_clear: assert property (
      q.state == prog_link_pkg::ST_CS_WR_DATA && rx_i.valid && !any_fault
      && q.addr[3:0] == `CSS_ADDR_STATUS && !rx_i.data[1]
      |=> !prog_enabled_o)
      else $error("writing zero did not disable programming");

   a_guard_write: assert property (
      q.state == prog_link_pkg::ST_CS_WR_DATA && rx_i.valid && !any_fault
      && q.addr[3:0] == `CSS_ADDR_LINK_CTRL
      |=> guard_time_sel_o == $past(rx_i.data[2:0]))
      else $error("guard time not taken from control write");

   a_key_length: assert property (
      q.state == prog_link_pkg::ST_IDLE && rx_i.valid && !any_fault
      && rx_i.data == 8'hE0
      |=> q.state == prog_link_pkg::ST_KEY_DATA && q.key_cnt == 4'h0)
      else $error("key instruction did not start key collection");

   a_fault_abort: assert property (
      any_fault && !error_o |=> error_o && !tx_valid_o && !io_write_o.valid)
      else $error("link fault did not abort into error state");

   a_error_hold: assert property (
      error_o && !fault_i.brk |=> error_o)
      else $error("error state left without a break");

endmodule

// ---- hw/prog_link_pkg.sv ----
// types and shared decoding of the programming link access layer
// assumes prog_link_regs.svh on the include path
`include "prog_link_regs.svh"

package prog_link_pkg;

   typedef enum logic [2:0]
   {
      ST_IDLE       = 3'b000,
      ST_IO_DATA    = 3'b001,
      ST_CS_WR_DATA = 3'b010,
      ST_CS_RD_WAIT = 3'b011,
      ST_CS_RD_SEND = 3'b100,
      ST_KEY_DATA   = 3'b101,
      ST_ERROR      = 3'b110
   } acc_state_t;

   typedef struct packed
   {
      logic       valid;
      logic [7:0] data;
   } rx_byte_t;

   typedef struct packed
   {
      logic       parity;
      logic       frame;
      logic       collision;
      logic       brk;
   } link_fault_t;

   typedef struct packed
   {
      logic       valid;
      logic [5:0] addr;
      logic [7:0] data;
   } io_write_t;

   typedef struct packed
   {
      acc_state_t  state;
      logic [5:0]  addr;
      logic [63:0] key;
      logic [3:0]  key_cnt;
      logic        prog_en;
      logic [2:0]  guard_sel;
      logic [7:0]  tx_byte;
      logic        tx_valid;
      logic        io_wr;
      logic [7:0]  byte_hold;
      logic        other_instr;
   } acc_regs_t;

   typedef struct packed
   {
      logic       busy;
      logic       done;
      logic [7:0] cnt;
   } turn_regs_t;

   // extra idle bits selected by the guard-time field
   function automatic logic [7:0] guard_idle_bits(input logic [2:0] sel);
      if (sel == `GUARD_SEL_NONE)
         guard_idle_bits = 8'h00;
      else
         guard_idle_bits = `GUARD_MAX_IDLE_BITS >> sel;
   endfunction

   // read value of the control/status space
   function automatic logic [7:0] css_read(input logic [3:0] addr,
                                           input logic       prog_en,
                                           input logic [2:0] guard_sel,
                                           input logic [7:0] ident);
      css_read = 8'h00;
      case (addr)
         `CSS_ADDR_STATUS:    css_read[`STATUS_PROG_EN_BIT] = prog_en;
         `CSS_ADDR_LINK_CTRL: css_read[`LINK_CTRL_GT_MSB:0] = guard_sel;
         `CSS_ADDR_IDENT:     css_read = ident;
         default:             css_read = 8'h00;
      endcase
   endfunction

endpackage

// ---- hw/prog_link_regs.svh ----
// offsets, field positions, reset values and counts of the access layer
// assumes inclusion by bare name from the package and the design modules
`ifndef PROG_LINK_REGS_SVH
`define PROG_LINK_REGS_SVH

// control/status space addresses
`define CSS_ADDR_STATUS        4'h0
`define CSS_ADDR_LINK_CTRL     4'h2
`define CSS_ADDR_IDENT         4'hF

// field positions
`define STATUS_PROG_EN_BIT     1
`define LINK_CTRL_GT_MSB       2

// reset values
`define STATUS_RESET           8'h00
`define GUARD_SEL_RESET        3'h0
// identification code, value is arbitrary
`define IDENT_CODE_DEFAULT     8'h5A

// instruction decoding, value after masking
`define OPC_IO_WRITE_MASK      8'h90
`define OPC_IO_WRITE_VAL       8'h90
`define OPC_CS_READ_MASK       8'hF0
`define OPC_CS_READ_VAL        8'h80
`define OPC_CS_WRITE_MASK      8'hF0
`define OPC_CS_WRITE_VAL       8'hC0
`define OPC_KEY_MASK           8'hFF
`define OPC_KEY_VAL            8'hE0

// unlock key and the index of its last byte
`define UNLOCK_KEY             64'h1289AB45CDD888FF
`define KEY_LAST_INDEX         4'h7

// turnaround: extra idle bits on top of the guard time
`define TURN_BASE_IDLE_BITS    8'h02
`define GUARD_MAX_IDLE_BITS    8'h80
`define GUARD_SEL_NONE         3'h7

`endif

// ---- hw/turnaround_timer.sv ----
// idle-bit counter for the receive-to-transmit turnaround
// assumes bit_tick_i is a one-cycle pulse per link bit time, same clock
`include "prog_link_regs.svh"

module turnaround_timer
(
   input  wire logic       clk_sys_i,
   input  wire logic       reset_i,
   input  wire logic       start_i,
   input  wire logic       abort_i,
   input  wire logic       bit_tick_i,
   input  wire logic [2:0] guard_sel_i,
   output logic            done_o
);

   prog_link_pkg::turn_regs_t q;
   prog_link_pkg::turn_regs_t d;

   always_comb
   begin
      d      = q;
      d.done = 1'b0;
      if (abort_i)
      begin
         d.busy = 1'b0;
      end
      else if (start_i)
      begin
         d.busy = 1'b1;
         d.cnt  = prog_link_pkg::guard_idle_bits(guard_sel_i)
                  + `TURN_BASE_IDLE_BITS;
      end
      else if (q.busy && bit_tick_i)
      begin
         if (q.cnt == 8'h01)
         begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end
         d.cnt = q.cnt - 8'h01;
      end
   end

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         q <= '0;
      else
         q <= d;
   end

   assign done_o = q.done;

   // ticks seen since start, and the count expected for that start
   logic [7:0] ticks_q;
   logic [7:0] want_q;

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ticks_q <= 8'h00;
         want_q  <= 8'h00;
      end
      else if (start_i)
      begin
         ticks_q <= 8'h00;
         want_q  <= prog_link_pkg::guard_idle_bits(guard_sel_i)
                    + `TURN_BASE_IDLE_BITS;
      end
      else if (q.busy && bit_tick_i)
      begin
         ticks_q <= ticks_q + 8'h01;
      end
   end

   a_idle_bit_total: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      done_o |-> ticks_q == want_q)
      else $error("turnaround ended after wrong number of idle bits");

   a_guard_decode: assert property (
      @(posedge clk_sys_i) disable iff (reset_i)
      start_i && !abort_i && guard_sel_i == 3'h0 |=> q.cnt == 8'h82)
      else $error("default guard time not 128 plus two idle bits");

endmodule

// ---- tb/prog_iface_access_layer_bench.sv ----
// self-checking bench of the programming link access layer
// assumes prog_link_pkg and the programmer model are compiled first
module prog_iface_access_layer_bench;
   timeunit 1ns;
   timeprecision 100ps;

   // identification value is arbitrary
   localparam logic [7:0]  IDENT = 8'hA6;
   localparam logic [63:0] KEY   = 64'h1289AB45CDD888FF;

   logic                       clk_sys;
   logic                       reset;
   prog_link_pkg::rx_byte_t    rx;
   prog_link_pkg::link_fault_t fault;
   logic                       bit_tick;
   logic                       tx_ready;
   logic                       tx_valid;
   logic [7:0]                 tx_byte;
   prog_link_pkg::io_write_t   io_write;
   logic                       prog_enabled;
   logic [2:0]                 guard_sel;
   logic                       error;
   logic [3:0]                 stall;
   logic                       other_instr;
   logic [7:0]                 other_opcode;
   logic [7:0]                 exp_op[$];
   logic [13:0]                exp_io[$];
   logic [7:0]                 exp_tx[$];
   logic [2:0]                 cur_gt;
   logic                       tick_on;
   int                         ticks;
   int                         cycles;
   int                         fail_count;
   int                         n_checks;
   logic [7:0]                 gt_bits [8] = '{8'h80, 8'h40, 8'h20,
      8'h10, 8'h08, 8'h04, 8'h02, 8'h00};

   prog_link_access #(.IDENT_CODE(IDENT)) DUT
   (
      .clk_sys_i        (clk_sys),
      .reset_i          (reset),
      .rx_i             (rx),
      .fault_i          (fault),
      .bit_tick_i       (bit_tick),
      .tx_ready_i       (tx_ready),
      .tx_valid_o       (tx_valid),
      .tx_byte_o        (tx_byte),
      .io_write_o       (io_write),
      .prog_enabled_o   (prog_enabled),
      .guard_time_sel_o (guard_sel),
      .error_o          (error),
      .other_instr_o    (other_instr),
      .other_opcode_o   (other_opcode)
   );

   prog_link_programmer prog
   (
      .clk_sys_i  (clk_sys),
      .tx_valid_i (tx_valid),
      .stall_i    (stall),
      .rx_o       (rx),
      .fault_o    (fault),
      .bit_tick_o (bit_tick),
      .tx_ready_o (tx_ready)
   );

   initial
      clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                        input string what);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: %s seen %h expected %h", $time, what, seen,
                  exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // watcher: each result takes the oldest expectation
   always @(posedge clk_sys)
   begin
      cycles++;
      if (tick_on && bit_tick)
         ticks++;
      if (io_write.valid === 1'b1)
      begin
         if (exp_io.size() == 0)
            check(16'h0001, 16'h0000, "unexpected io write");
         else
            check({2'b00, io_write.addr, io_write.data},
                  {2'b00, exp_io.pop_front()}, "io write");
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         if (exp_tx.size() == 0)
            check(16'h0001, 16'h0000, "unexpected read-out");
         else
            check({8'h00, tx_byte}, {8'h00, exp_tx.pop_front()}, "read");
      end
      if (other_instr === 1'b1)
      begin
         if (exp_op.size() == 0)
            check(16'h0001, 16'h0000, "unexpected pass-on");
         else
            check({8'h00, other_opcode}, {8'h00, exp_op.pop_front()},
                  "opcode pass-on");
      end
      if (cycles == 30000)
      begin
         fail_count++;
         test_done();
      end
   end

   task automatic wait_tx(input logic lvl);
      int n;
      n = 0;
      while (tx_valid !== lvl && n < 3000)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask

   task automatic css_rd(input logic [3:0] a, input logic [7:0] exp);
      exp_tx.push_back(exp);
      prog.send_byte({4'h8, a});
      ticks = 0;
      tick_on = 1'b1;
      wait_tx(1'b1);
      tick_on = 1'b0;
      check(16'(ticks), {8'h00, gt_bits[cur_gt]} + 16'h0002, "idle");
      wait_tx(1'b0);
   endtask

   task automatic css_wr(input logic [3:0] a, input logic [7:0] d);
      prog.send_byte({4'hC, a});
      prog.send_byte(d);
      @(posedge clk_sys);
      #1;
   endtask

   task automatic io_wr(input logic [7:0] op, input logic [7:0] d);
      exp_io.push_back({op[6:5], op[3:0], d});
      prog.send_byte(op);
      prog.send_byte(d);
   endtask

   initial
   begin
      logic [7:0] r;
      logic [7:0] op;
      void'($urandom(32'h3823));
      reset = 1'b1;
      stall = 4'h0;
      tick_on = 1'b0;
      ticks = 0;
      cycles = 0;
      fail_count = 0;
      n_checks = 0;
      cur_gt = 3'h0;
      repeat (10) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      check(16'(prog_enabled), 16'h0000, "enable at reset");
      check(16'(guard_sel), 16'h0000, "guard at reset");
      css_rd(4'h0, 8'h00);
      css_rd(4'h2, 8'h00);
      css_rd(4'hF, IDENT);
      // fault while a read-out waits for its turnaround
      prog.send_byte(8'h8F);
      repeat (4) @(posedge clk_sys);
      prog.send_fault(4'h8);
      check(16'(error), 16'h0001, "fault to error");
      check(16'(tx_valid), 16'h0000, "read-out aborted");
      for (int k = 0; k < 3; k++)
      begin
         prog.send_fault(4'h1);
         check(16'(error), 16'h0000, "break leaves error");
         prog.send_fault(4'h8 >> k);
         check(16'(error), 16'h0001, "fault kind");
         prog.send_byte(8'h90);
         prog.send_byte(8'h33);
      end
      prog.send_fault(4'h1);
      check(16'(error), 16'h0000, "break resync");
      // shortest guard until the guard-field sweep at the end
      css_wr(4'h2, 8'h07);
      cur_gt = 3'h7;
      for (int a = 1; a < 15; a++)
         if (a != 2)
         begin
            css_wr(a[3:0], 8'hFF);
            css_rd(a[3:0], 8'h00);
         end
      css_rd(4'h0, 8'h00);
      css_rd(4'h2, 8'h07);
      r = 8'($urandom_range(7));
      prog.send_key(KEY ^ (64'h1 << (8 * r)));
      repeat (2) @(posedge clk_sys);
      #1;
      check(16'(prog_enabled), 16'h0000, "wrong key");
      prog.send_byte(8'hE0);
      prog.send_byte(KEY[7:0]);
      prog.send_fault(4'h2 << $urandom_range(2));
      prog.send_fault(4'h1);
      prog.send_key(KEY);
      css_rd(4'h0, 8'h02);
      check(16'(prog_enabled), 16'h0001, "key enables");
      for (int i = 0; i < 8; i++)
      begin
         op = 8'h90 | (8'($urandom) & 8'h6F);
         if (i < 3)
            op = (i == 0) ? 8'h90 : ((i == 1) ? 8'h92 : 8'hFF);
         io_wr(op, 8'($urandom));
      end
      // opcodes handled elsewhere are passed on and consume no operand
      for (int i = 0; i < 2; i++)
      begin
         op = 8'h20 | (8'($urandom) & 8'h44);
         exp_op.push_back(op);
         prog.send_byte(op);
      end
      check(16'(prog_enabled), 16'h0001, "io leaves status");
      check(16'(guard_sel), 16'h0007, "io leaves link ctrl");
      css_wr(4'h0, 8'h02);
      check(16'(prog_enabled), 16'h0001, "write one kept");
      css_wr(4'h0, 8'($urandom) & 8'hFD);
      check(16'(prog_enabled), 16'h0000, "write zero");
      css_rd(4'h0, 8'h00);
      stall = 4'($urandom_range(6, 1));
      for (int g = 0; g < 8; g++)
      begin
         r = 8'($urandom);
         css_wr(4'h2, {r[7:3], g[2:0]});
         cur_gt = g[2:0];
         check(16'(guard_sel), 16'(cur_gt), "guard field");
         css_rd(4'h2, {5'h00, cur_gt});
      end
      repeat (4) @(posedge clk_sys);
      check(16'(exp_io.size() + exp_tx.size() + exp_op.size()), 16'h0000,
            "results left unseen");
      test_done();
   end
endmodule

// ---- tb/prog_link_programmer.sv ----
// behavioural external programmer facing the access layer
// assumes the bench owns clock and reset and calls the send tasks
module prog_link_programmer
(
   input  wire logic                  clk_sys_i,
   input  wire logic                  tx_valid_i,
   input  wire logic [3:0]            stall_i,
   output prog_link_pkg::rx_byte_t    rx_o,
   output prog_link_pkg::link_fault_t fault_o,
   output logic                       bit_tick_o,
   output logic                       tx_ready_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [1:0] tick_div;
   logic [3:0] wait_cnt;
   logic       hs;

   initial
   begin
      rx_o = '0;
      fault_o = '0;
      bit_tick_o = 1'b0;
      tx_ready_o = 1'b0;
      tick_div = 2'h0;
      wait_cnt = 4'h0;
   end

   // bit tick every fourth clock; read-out accepted after stall_i cycles
   always @(posedge clk_sys_i)
   begin
      hs = tx_valid_i && tx_ready_o;
      #1;
      tick_div = tick_div + 2'h1;
      bit_tick_o = (tick_div == 2'h0);
      if (hs || !tx_valid_i)
      begin
         tx_ready_o = 1'b0;
         wait_cnt = 4'h0;
      end
      else if (wait_cnt == stall_i)
         tx_ready_o = 1'b1;
      else
         wait_cnt = wait_cnt + 4'h1;
   end

   // released data line shows the inverse of the last byte
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk_sys_i);
      #1;
      rx_o = '{valid: 1'b1, data: b};
      @(posedge clk_sys_i);
      #1;
      rx_o = '{valid: 1'b0, data: ~b};
   endtask

   task automatic send_fault(input logic [3:0] f);
      @(posedge clk_sys_i);
      #1;
      fault_o = f;
      @(posedge clk_sys_i);
      #1;
      fault_o = '0;
   endtask

   // key instruction then exactly eight bytes, least significant first
   task automatic send_key(input logic [63:0] k);
      send_byte(8'hE0);
      for (int i = 0; i < 8; i++)
         send_byte(k[8*i +: 8]);
   endtask
endmodule
